// File: hdl/counter_array_pkg.sv
package counter_array_pkg;

  localparam int unsigned NUM_CH = 6;

  // Register byte addresses
  localparam logic [11:0] ADDR_CONTROL = 12'h000;
  localparam logic [11:0] ADDR_MODE = 12'h004;
  localparam logic [11:0] ADDR_COUNT_LO = 12'h008;
  localparam logic [11:0] ADDR_COUNT_HI = 12'h00C;
  localparam logic [11:0] ADDR_PWM_CTRL = 12'h010;
  localparam logic [11:0] ADDR_PIN_LEVEL = 12'h014;
  localparam logic [11:0] ADDR_CH_MODE = 12'h020;
  localparam logic [11:0] ADDR_CMP_LO = 12'h040;
  localparam logic [11:0] ADDR_CMP_HI = 12'h060;
  localparam logic [11:0] CH_SPAN = 12'h018;

  // Field positions
  localparam int unsigned CTRL_MAIN_OVF_BIT = 7;
  localparam int unsigned CTRL_RUN_BIT = 6;
  localparam int unsigned MODE_MAIN_IRQ_EN_BIT = 0;
  localparam int unsigned MODE_TB_LSB = 1;
  localparam int unsigned PWM_ARSEL_BIT = 7;
  localparam int unsigned PWM_INT_OVF_BIT = 6;
  localparam int unsigned PWM_INT_IRQ_EN_BIT = 5;

  // Reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [15:0] FULL_MASK = 16'hFFFF;

  // Timebase selections
  localparam logic [2:0] TB_DIV12 = 3'h0;
  localparam logic [2:0] TB_DIV4 = 3'h1;
  localparam logic [2:0] TB_TIMER0 = 3'h2;
  localparam logic [2:0] TB_EXT_PIN = 3'h3;
  localparam logic [2:0] TB_SYSCLK = 3'h4;
  localparam logic [2:0] TB_EXT_OSC = 3'h5;
  localparam logic [3:0] PRESC_LAST = 4'hB;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [2:0] OSC_DIV_LAST = 3'h7;

  typedef enum logic {APB_IDLE = 1'b0, APB_ANSWER = 1'b1} apb_phase_t;

  typedef struct packed {
    logic pwm16;
    logic ecom;
    logic capp;
    logic capn;
    logic mat;
    logic tog;
    logic pwm;
    logic irq_en;
  } chan_mode_t;

  typedef struct packed {
    chan_mode_t mode;
    logic [15:0] cmp;
    logic [1:0] len;
  } chan_cfg_t;

  function automatic logic [15:0] len_mask(input logic [1:0] len);
    unique case (len)
      2'h0: len_mask = 16'h00FF;
      2'h1: len_mask = 16'h01FF;
      2'h2: len_mask = 16'h03FF;
      2'h3: len_mask = 16'h07FF;
    endcase
  endfunction

endpackage

// File: hdl/counter_array_channel.sv
`timescale 1ns/1ps
module counter_array_channel
  import counter_array_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire chan_cfg_t cfg_in,
  input wire logic [15:0] count_in,
  input wire logic fresh_in,
  input wire logic pin_in,
  output logic capture_out,
  output logic match_out,
  output logic level_out,
  output logic pin_out,
  output logic pin_oe_out
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic prev;
    logic pin;
    logic oe;
  } chan_state_t;

  chan_state_t s_r;
  chan_state_t s_nxt;

  always_comb begin
    logic rise;
    logic fall;
    logic hit;
    logic wrap;
    logic [15:0] mask;
    chan_mode_t m;
    rise = 1'b0;
    fall = 1'b0;
    hit = 1'b0;
    wrap = 1'b0;
    mask = FULL_MASK;
    m = cfg_in.mode;
    s_nxt = s_r;
    // Pin synchroniser and edge detect on the second stage
    s_nxt.s1 = pin_in;
    s_nxt.s2 = s_r.s1;
    s_nxt.prev = s_r.s2;
    rise = s_r.s2 & ~s_r.prev;
    fall = ~s_r.s2 & s_r.prev;
    capture_out = (m.capp | m.capn) & ~m.mat & ~m.tog & ~m.pwm
      & ((m.capp & rise) | (m.capn & fall));
    // Short compare in 8 to 11 bit PWM
    if (m.pwm && !m.pwm16 && !m.tog) begin
      mask = len_mask(cfg_in.len);
    end
    hit = m.ecom & fresh_in & (((count_in ^ cfg_in.cmp) & mask) == RESET_WORD);
    wrap = fresh_in & ((count_in & mask) == RESET_WORD);
    match_out = hit & m.mat;
    if (m.tog && !m.pwm) begin
      if (hit) begin
        s_nxt.pin = ~s_r.pin;
      end
    end else if (m.pwm && !m.tog) begin
      if (!m.ecom) begin
        s_nxt.pin = 1'b0;
      end else if (hit) begin
        s_nxt.pin = 1'b1;
      end else if (wrap) begin
        s_nxt.pin = 1'b0;
      end
    end
    s_nxt.oe = m.tog | m.pwm;
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_out = s_r.s2;
  assign pin_out = s_r.pin;
  assign pin_oe_out = s_r.oe;

endmodule // counter_array_channel

// File: hdl/counter_array.sv
// Overview of operation
// - Main overflow flag sets when the 16-bit counter wraps from all ones.
// - Intermediate overflow flag sets on overflow out of bit 7, 8, 9 or 10.
// - Every event flag sets on its trigger regardless of interrupt enables.
// - Interrupt request rises when any flag is set with its own enable.
// - Mode bits 5/4 pick rising, falling or any-edge capture, bits 3-1 clear.
// - Bits 7 and 2 clear, bit 1 set picks short PWM; length field gives 8-11 bits.
// - One cycle-length setting is shared by all short-PWM channels.
// - PWM control bit 7 steers compare byte addresses to auto-reload registers.
// - Comparator disabled: no match, no toggle, PWM output held at 0.
// - In PWM modes a match sets the channel flag when match enable is set.
// - PWM control bit 5 enables interrupt from the intermediate overflow flag.
// - Selected pin edge in capture mode copies counter and sets channel flag.
// - Flags are never cleared by servicing; software clears them explicitly.
// - Software timer: counter equal to compare value sets the channel flag.
// - Compare low write clears comparator enable; high write sets it.
// - High-speed output toggles the pin and sets the flag on each match.
// - High-speed output with comparator off keeps pin level, no toggle.
// - Synchronised pin levels stay readable to tell which edge captured.
// - Counter low read latches high byte; next high read returns snapshot.
// - Timebase field picks div12, div4, timer0, external pin, clock, osc/8.
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module counter_array
  import counter_array_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic timer0_overflow_in,
  input wire logic external_count_pin_in,
  input wire logic ext_osc_in,
  input wire logic [5:0] channel_pin_in,
  output logic [5:0] channel_pin_out,
  output logic [5:0] channel_pin_oe_out,
  output logic irq_out
);

  typedef struct packed {
    apb_phase_t phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic run;
    logic main_ovf_flag;
    logic main_irq_en;
    logic [2:0] timebase;
    logic arsel;
    logic int_ovf_flag;
    logic int_irq_en;
    logic [1:0] len;
    logic [5:0] ch_flag;
    chan_mode_t [5:0] mode;
    logic [5:0][15:0] cmp;
    logic [5:0][15:0] reload;
    logic [15:0] count;
    logic [7:0] snap;
    logic fresh;
    logic [3:0] presc;
    logic eci_s1;
    logic eci_s2;
    logic eci_prev;
    logic osc_s1;
    logic osc_s2;
    logic osc_prev;
    logic [2:0] osc_div;
  } top_state_t;

  top_state_t s_r;
  top_state_t s_nxt;

  logic [5:0] capture;
  logic [5:0] match;
  logic [5:0] level;

  // Channel register group decode: hit flag and channel index
  function automatic logic [3:0] ch_decode(input logic [11:0] addr, input logic [11:0] base);
    logic [11:0] diff;
    diff = addr - base;
    ch_decode = {(addr >= base) && (diff < CH_SPAN) && (diff[1:0] == 2'h0), diff[4:2]};
  endfunction

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    counter_array_channel u_ch (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .cfg_in('{mode: s_r.mode[i], cmp: s_r.cmp[i], len: s_r.len}),
      .count_in(s_r.count),
      .fresh_in(s_r.fresh),
      .pin_in(channel_pin_in[i]),
      .capture_out(capture[i]),
      .match_out(match[i]),
      .level_out(level[i]),
      .pin_out(channel_pin_out[i]),
      .pin_oe_out(channel_pin_oe_out[i])
    );
  end

  always_comb begin
    logic tick;
    logic main_evt;
    logic int_evt;
    logic [15:0] mask;
    logic [3:0] dm;
    logic [3:0] dl;
    logic [3:0] dh;
    logic [31:0] rd;
    logic mapped;
    logic [5:0] irq_en_vec;
    tick = 1'b0;
    main_evt = 1'b0;
    int_evt = 1'b0;
    mask = len_mask(s_r.len);
    dm = ch_decode(paddr_in, ADDR_CH_MODE);
    dl = ch_decode(paddr_in, ADDR_CMP_LO);
    dh = ch_decode(paddr_in, ADDR_CMP_HI);
    rd = 32'h0000_0000;
    mapped = 1'b1;
    irq_en_vec = 6'h00;
    s_nxt = s_r;

    // Timebase sources
    s_nxt.presc = (s_r.presc == PRESC_LAST) ? 4'h0 : s_r.presc + 4'h1;
    s_nxt.eci_s1 = external_count_pin_in;
    s_nxt.eci_s2 = s_r.eci_s1;
    s_nxt.eci_prev = s_r.eci_s2;
    s_nxt.osc_s1 = ext_osc_in;
    s_nxt.osc_s2 = s_r.osc_s1;
    s_nxt.osc_prev = s_r.osc_s2;
    if (s_r.osc_s2 && !s_r.osc_prev) begin
      s_nxt.osc_div = s_r.osc_div + 3'h1;
    end
    case (s_r.timebase)
      TB_DIV12: tick = (s_r.presc == PRESC_LAST);
      TB_DIV4: tick = (s_r.presc[1:0] == DIV4_LAST);
      TB_TIMER0: tick = timer0_overflow_in;
      TB_EXT_PIN: tick = ~s_r.eci_s2 & s_r.eci_prev;
      TB_SYSCLK: tick = 1'b1;
      TB_EXT_OSC: tick = s_r.osc_s2 & ~s_r.osc_prev & (s_r.osc_div == OSC_DIV_LAST);
      default: tick = 1'b0;
    endcase
    tick = tick & s_r.run;

    // Counter and overflow events
    s_nxt.fresh = tick;
    if (tick) begin
      s_nxt.count = s_r.count + 16'h0001;
    end
    main_evt = tick & (s_r.count == FULL_MASK);
    int_evt = tick & ((s_r.count & mask) == mask);

    // Auto-reload of short-PWM channels at the N-bit overflow
    for (int i = 0; i < NUM_CH; i++) begin
      if (int_evt && s_r.mode[i].pwm && !s_r.mode[i].pwm16 && !s_r.mode[i].tog) begin
        if (s_r.len == 2'h0) begin
          s_nxt.cmp[i][7:0] = s_r.cmp[i][15:8];
        end else begin
          s_nxt.cmp[i] = s_r.reload[i];
        end
      end
    end

    // Register read mux
    if (paddr_in == ADDR_CONTROL) begin
      rd[7:0] = {s_r.main_ovf_flag, s_r.run, s_r.ch_flag};
    end else if (paddr_in == ADDR_MODE) begin
      rd[3:0] = {s_r.timebase, s_r.main_irq_en};
    end else if (paddr_in == ADDR_COUNT_LO) begin
      rd[7:0] = s_r.count[7:0];
    end else if (paddr_in == ADDR_COUNT_HI) begin
      rd[7:0] = s_r.snap;
    end else if (paddr_in == ADDR_PWM_CTRL) begin
      rd[7:0] = {s_r.arsel, s_r.int_ovf_flag, s_r.int_irq_en, 3'h0, s_r.len};
    end else if (paddr_in == ADDR_PIN_LEVEL) begin
      rd[5:0] = level;
    end else if (dm[3]) begin
      rd[7:0] = s_r.mode[dm[2:0]];
    end else if (dl[3]) begin
      rd[7:0] = s_r.arsel ? s_r.reload[dl[2:0]][7:0] : s_r.cmp[dl[2:0]][7:0];
    end else if (dh[3]) begin
      rd[7:0] = s_r.arsel ? s_r.reload[dh[2:0]][15:8] : s_r.cmp[dh[2:0]][15:8];
    end else begin
      mapped = 1'b0;
    end

    // APB slave: answer registered in the setup cycle, acts at access end
    unique case (s_r.phase)
      APB_IDLE: begin
        if (psel_in && !penable_in) begin
          s_nxt.phase = APB_ANSWER;
          s_nxt.pready = 1'b1;
          s_nxt.pslverr = ~mapped;
          s_nxt.prdata = pwrite_in ? 32'h0000_0000 : rd;
          if (!pwrite_in && paddr_in == ADDR_COUNT_LO) begin
            s_nxt.snap = s_r.count[15:8];
          end
        end
      end
      APB_ANSWER: begin
        s_nxt.phase = APB_IDLE;
        s_nxt.pready = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (psel_in && penable_in && mapped && pwrite_in) begin
          if (paddr_in == ADDR_CONTROL) begin
            s_nxt.main_ovf_flag = pwdata_in[CTRL_MAIN_OVF_BIT];
            s_nxt.run = pwdata_in[CTRL_RUN_BIT];
            s_nxt.ch_flag = pwdata_in[5:0];
          end else if (paddr_in == ADDR_MODE) begin
            s_nxt.main_irq_en = pwdata_in[MODE_MAIN_IRQ_EN_BIT];
            s_nxt.timebase = pwdata_in[MODE_TB_LSB +: 3];
          end else if (paddr_in == ADDR_COUNT_LO) begin
            s_nxt.count[7:0] = pwdata_in[7:0];
          end else if (paddr_in == ADDR_COUNT_HI) begin
            s_nxt.count[15:8] = pwdata_in[7:0];
          end else if (paddr_in == ADDR_PWM_CTRL) begin
            s_nxt.arsel = pwdata_in[PWM_ARSEL_BIT];
            s_nxt.int_ovf_flag = pwdata_in[PWM_INT_OVF_BIT];
            s_nxt.int_irq_en = pwdata_in[PWM_INT_IRQ_EN_BIT];
            s_nxt.len = pwdata_in[1:0];
          end else if (dm[3]) begin
            s_nxt.mode[dm[2:0]] = pwdata_in[7:0];
          end else if (dl[3]) begin
            if (s_r.arsel) begin
              s_nxt.reload[dl[2:0]][7:0] = pwdata_in[7:0];
            end else begin
              s_nxt.cmp[dl[2:0]][7:0] = pwdata_in[7:0];
            end
            s_nxt.mode[dl[2:0]].ecom = 1'b0;
          end else if (dh[3]) begin
            if (s_r.arsel) begin
              s_nxt.reload[dh[2:0]][15:8] = pwdata_in[7:0];
            end else begin
              s_nxt.cmp[dh[2:0]][15:8] = pwdata_in[7:0];
            end
            s_nxt.mode[dh[2:0]].ecom = 1'b1;
          end
        end
      end
    endcase

    // Hardware events set flags after software writes, so the set wins
    if (main_evt) begin
      s_nxt.main_ovf_flag = 1'b1;
    end
    if (int_evt) begin
      s_nxt.int_ovf_flag = 1'b1;
    end
    for (int i = 0; i < NUM_CH; i++) begin
      if (capture[i]) begin
        s_nxt.cmp[i] = s_r.count;
      end
      if (capture[i] || match[i]) begin
        s_nxt.ch_flag[i] = 1'b1;
      end
      irq_en_vec[i] = s_nxt.mode[i].irq_en;
    end

    // Interrupt request from flags and their enables
    s_nxt.irq = (s_nxt.main_ovf_flag & s_nxt.main_irq_en)
      | (s_nxt.int_ovf_flag & s_nxt.int_irq_en)
      | (|(s_nxt.ch_flag & irq_en_vec));
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata_out = s_r.prdata;
  assign pready_out = s_r.pready;
  assign pslverr_out = s_r.pslverr;
  assign irq_out = s_r.irq;

endmodule // counter_array

// File: sim/counter_array_monitor.sv
`timescale 1ns/1ps
module counter_array_monitor
  import counter_array_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [5:0] channel_pin_in,
  input wire logic [5:0] channel_pin_out,
  input wire logic [5:0] channel_pin_oe_out,
  input wire logic irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  pready_setup_a: assert property (psel_in && !penable_in |=> pready_out)
    else $error("ready missing");
  pready_pulse_a: assert property (pready_out |=> !pready_out)
    else $error("ready too long");
  ready_cause_a: assert property ($rose(pready_out) |-> $past(psel_in && !penable_in))
    else $error("ready without setup");
  slverr_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("error without ready");
  rdata_upper_a: assert property (pready_out |-> prdata_out[31:8] == 24'h000000)
    else $error("upper read bits set");
  irq_hold_a: assert property ($fell(irq_out) |-> $past(psel_in && penable_in && pwrite_in))
    else $error("irq dropped without write");
  pin_level_a: assert property (pready_out && !pwrite_in && paddr_in == ADDR_PIN_LEVEL &&
    $past(channel_pin_in) == $past(channel_pin_in, 4) |-> prdata_out[5:0] == $past(channel_pin_in))
    else $error("pin level wrong");
  pin_drive_a: assert property (((channel_pin_out ^ $past(channel_pin_out)) & ~channel_pin_oe_out
    & ~$past(channel_pin_oe_out)) == 6'h00)
    else $error("undriven pin moved");
endmodule // counter_array_monitor
bind counter_array counter_array_monitor mon (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
  .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .prdata_out(prdata_out),
  .pready_out(pready_out), .pslverr_out(pslverr_out), .channel_pin_in(channel_pin_in),
  .channel_pin_out(channel_pin_out), .channel_pin_oe_out(channel_pin_oe_out), .irq_out(irq_out));

// File: sim/pin_driver.sv
`timescale 1ns/1ps
module pin_driver (
  input wire logic clk_in,
  input wire logic [5:0] level_req_in,
  output logic [5:0] pin_out
);
  logic [2:0] hold_r;
  initial begin
    pin_out = 6'h00;
    hold_r = 3'h0;
  end
  // Each level stands four clocks or more
  always @(posedge clk_in) begin
    if (hold_r != 3'h0) begin
      hold_r <= hold_r - 3'h1;
    end else if (level_req_in != pin_out) begin
      pin_out <= level_req_in;
      hold_r <= 3'h3;
    end
  end
endmodule // pin_driver

// File: sim/tb_counter_array.sv
`timescale 1ns/1ps
module tb_counter_array
  import counter_array_pkg::*;
;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, v, e;
  logic pready, pslverr, irq, err, p0, t0 = 1'b0, external_count_pin = 1'b0, osc = 1'b0;
  logic [5:0] pin_req = 6'h00, pin_in, pin_out, pin_oe, r;
  logic [15:0] c, t;
  int seed = 84, num_errors = 0, cmp_count = 0, cycles = 0;
  logic global_irq_enable = 1'b1, array_irq_enable = 1'b1;
  always #12.5 clk_in = ~clk_in;
  counter_array DUT (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .timer0_overflow_in(t0),
    .external_count_pin_in(external_count_pin), .ext_osc_in(osc), .channel_pin_in(pin_in),
    .channel_pin_out(pin_out), .channel_pin_oe_out(pin_oe), .irq_out(irq));
  pin_driver pins (.clk_in(clk_in), .level_req_in(pin_req), .pin_out(pin_in));
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk_in) begin
    {t0, external_count_pin, osc} <= 3'($random(seed));
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
    end while (pready !== 1'b1);
    v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cnt;
    rd(ADDR_COUNT_LO);
    c[7:0] = v[7:0];
    rd(ADDR_COUNT_HI);
    c[15:8] = v[7:0];
  endtask
  task automatic setcmp(input logic [11:0] ch, input logic [15:0] val);
    wr(ADDR_CMP_LO + ch, {24'h0, val[7:0]});
    wr(ADDR_CMP_HI + ch, {24'h0, val[15:8]});
  endtask
  function automatic logic [31:0] pwm_exp(input logic [1:0] len, input logic [7:0] hi);
    logic [16:0] m;
    m = (17'h00100 << len) - 17'h00001;
    pwm_exp = {24'h0, 1'b0, (({1'b0, hi, 8'hF0} & m) + 17'h00010) > m, 4'h8, len};
  endfunction
  // Bounds of the tick count in a 243-cycle run window, per timebase
  function automatic logic [31:0] tb_range(input int sel);
    case (sel)
      0: tb_range = {16'd19, 16'd22};
      1: tb_range = {16'd59, 16'd62};
      2: tb_range = {16'd90, 16'd155};
      3: tb_range = {16'd35, 16'd90};
      4: tb_range = {16'd241, 16'd245};
      default: tb_range = {16'd3, 16'd13};
    endcase
  endfunction
  initial begin
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(ADDR_CONTROL);
    check(v, 32'h0);
    rd(ADDR_MODE);
    check(v, 32'h0);
    wr(12'hFFC, 32'hFF);
    check(32'(err), 32'h1);
    rd(12'h002);
    check(32'(err), 32'h1);
    // Software timer on channel 0
    wr(ADDR_MODE, 32'h08);
    wr(ADDR_CH_MODE, 32'h48);
    t = 16'h0040 + 16'($random(seed) & 32'h3F);
    wr(ADDR_CMP_LO, {24'h0, t[7:0]});
    rd(ADDR_CH_MODE);
    check(v, 32'h08);
    wr(ADDR_CMP_HI, {24'h0, t[15:8]});
    rd(ADDR_CH_MODE);
    check(v, 32'h48);
    wr(ADDR_CONTROL, 32'h40);
    repeat (200) @(posedge clk_in);
    check(32'(irq), 32'h0);
    rd(ADDR_CONTROL);
    check(v, 32'h41);
    wr(ADDR_CH_MODE, 32'h49);
    @(posedge clk_in);
    check(32'(irq), 32'h1);
    check(32'(irq & global_irq_enable & array_irq_enable), 32'h1);
    repeat (20) @(posedge clk_in);
    rd(ADDR_CONTROL);
    check(v, 32'h41);
    wr(ADDR_CONTROL, 32'h40);
    @(posedge clk_in);
    check(32'(irq), 32'h0);
    wr(ADDR_CH_MODE, 32'h48);
    // Capture on channel 1, each edge against each select
    for (int k = 0; k < 6; k++) begin
      logic [7:0] sel;
      logic lvl, fl;
      sel = (k < 2) ? 8'h20 : (k < 4) ? 8'h10 : 8'h30;
      lvl = k[0];
      r = 6'($random(seed));
      r[1] = lvl;
      pin_req <= r;
      repeat (8) @(posedge clk_in);
      wr(ADDR_CH_MODE + 12'h004, {24'h0, sel});
      wr(ADDR_CONTROL, 32'h40);
      cnt();
      pin_req[1] <= ~lvl;
      repeat (10) @(posedge clk_in);
      rd(ADDR_PIN_LEVEL);
      check(32'(v[1]), {31'h0, ~lvl});
      rd(ADDR_CONTROL);
      fl = lvl ? sel[4] : sel[5];
      check(32'(v[1]), 32'(fl));
      if (fl) begin
        rd(ADDR_CMP_LO + 12'h004);
        t[7:0] = v[7:0];
        rd(ADDR_CMP_HI + 12'h004);
        t[15:8] = v[7:0];
        check(32'((t - c) < 16'd24 && (t - c) > 16'd0), 32'h1);
      end
    end
    // Toggle output on channel 2
    wr(ADDR_CH_MODE + 12'h008, 32'h4C);
    cnt();
    setcmp(12'h008, c + 16'd24 + 16'($random(seed) & 32'hF));
    p0 = pin_out[2];
    repeat (60) @(posedge clk_in);
    check(32'(pin_out[2]), {31'h0, ~p0});
    rd(ADDR_CONTROL);
    check(v & 32'h4, 32'h4);
    cnt();
    setcmp(12'h008, c + 16'd24);
    wr(ADDR_CH_MODE + 12'h008, 32'h0C);
    wr(ADDR_CONTROL, 32'h40);
    p0 = pin_out[2];
    repeat (60) @(posedge clk_in);
    check(32'(pin_out[2]), 32'(p0));
    rd(ADDR_CONTROL);
    check(v & 32'h4, 32'h0);
    // Overflow flags for every cycle length
    wr(ADDR_CH_MODE + 12'h00C, 32'h02);
    for (int i = 0; i < 12; i++) begin
      logic [1:0] len;
      logic [7:0] hi;
      len = 2'(i);
      hi = (i < 4) ? (8'h01 << len) - 8'h01 : (i < 8) ? (8'h02 << len) - 8'h02 :
        (i == 8) ? 8'hFF : 8'($random(seed));
      wr(ADDR_CONTROL, 32'h0);
      wr(ADDR_PWM_CTRL, {26'h0, 4'h8, len});
      wr(ADDR_COUNT_HI, {24'h0, hi});
      wr(ADDR_COUNT_LO, 32'hF0);
      wr(ADDR_CONTROL, 32'h40);
      repeat (40) @(posedge clk_in);
      e = pwm_exp(len, hi);
      rd(ADDR_PWM_CTRL);
      check(v, e);
      check(32'(irq), 32'(e[6]));
      rd(ADDR_CONTROL);
      check(v & 32'h80, (hi == 8'hFF) ? 32'h80 : 32'h0);
    end
    // Eight-bit PWM on channel 3, high time counted over two periods
    wr(ADDR_CONTROL, 32'h0);
    wr(ADDR_PWM_CTRL, 32'h0);
    wr(ADDR_COUNT_LO, 32'h0);
    wr(ADDR_COUNT_HI, 32'h0);
    t[7:0] = 8'h40 + 8'($random(seed) & 32'h7F);
    setcmp(12'h00C, {t[7:0], t[7:0]});
    wr(ADDR_CH_MODE + 12'h00C, 32'h4A);
    wr(ADDR_CONTROL, 32'h40);
    t = 16'd512 - {7'h0, t[7:0], 1'b0};
    c = 16'h0000;
    repeat (512) begin
      @(posedge clk_in);
      c = c + 16'(pin_out[3]);
    end
    check(32'(c + 16'd3 >= t && c <= t + 16'd3), 32'h1);
    rd(ADDR_CONTROL);
    check(v & 32'h8, 32'h8);
    wr(ADDR_CH_MODE + 12'h00C, 32'h02);
    // Every timebase over the same run window
    for (int i = 0; i < 6; i++) begin
      logic [31:0] rg;
      rg = tb_range(i);
      wr(ADDR_CONTROL, 32'h0);
      wr(ADDR_COUNT_LO, 32'h0);
      wr(ADDR_COUNT_HI, 32'h0);
      wr(ADDR_MODE, 32'(i) << MODE_TB_LSB);
      wr(ADDR_CONTROL, 32'h40);
      repeat (240) @(posedge clk_in);
      wr(ADDR_CONTROL, 32'h0);
      cnt();
      check(32'(c >= rg[31:16] && c <= rg[15:0]), 32'h1);
    end
    check({30'h0, pin_oe[3], pin_out[3]}, 32'h2);
    wrap_up();
  end
endmodule // tb_counter_array
